// [logic/cpu_mode_control.v]
// Front-panel operating mode and restart sequencer with AHB-Lite registers
`timescale 1ns/100ps
`include "front_panel_defs.vh"
// Operation
// - With the selector at run and the run lamp lit without the stop lamp, the user program is executing.
// - Moving the selector from run to stop puts the device into soft stop; a move during the cold-restart clear or entry block is ignored and run follows.
// - Overall reset and both restarts start only from selector plus reset-switch settings.
// - Reset switch down gives an overall reset that erases and reinitialises internal RAM.
// - In an overall reset an inserted memory card is copied into RAM after the erase.
// - After the RAM reinitialisation of an overall reset a full self-test runs.
// - Reset switch up gives a cold restart clearing flags, timers, counters and image.
// - Reset switch middle restarts the program with all retained state left unchanged.
// - The stop lamp shows soft stop and the system fault lamp shows hard stop.
// - In soft stop the stop cycle block may run but digital outputs stay disabled.
// - In hard stop no program runs and the device stands still.
// - Hard stop ignores all switches and is left only through power-on reset.
// - All three lamps light only briefly just after power-on.

module cpu_mode_control #(
    parameter DEBOUNCE_TICKS  = `DEBOUNCE_TICKS,
    parameter LAMP_TEST_TICKS = `LAMP_TEST_TICKS
) (
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    output reg         irq,
    // Front-panel pins
    input  wire        mode_run_sw,
    input  wire        reset_up_sw,
    input  wire        reset_down_sw,
    input  wire        card_inserted,
    output reg         run_lamp,
    output reg         stop_lamp,
    output reg         system_fault_lamp,
    // Program sequencer and memory side
    input  wire        hard_fault,
    input  wire        ram_erase_done,
    input  wire        card_copy_done,
    input  wire        self_test_done,
    input  wire        self_test_fail,
    input  wire        state_clear_done,
    input  wire        entry_block_done,
    output reg         ram_erase_req,
    output reg         card_copy_req,
    output reg         self_test_req,
    output reg         state_clear_req,
    output reg         restart_entry_block,
    output reg         program_restart,
    output reg         user_program_run,
    output reg         stop_cycle_block,
    output reg         outputs_enable
);

    localparam integer LAMP_SPAN = LAMP_TEST_TICKS - 1;
    localparam [19:0]  LAMP_LAST = LAMP_SPAN[19:0];

    // ==========================================================
    // Microsecond tick
    // Free-running from reset; lamp test and debounce share this time base
    reg  [6:0] tick_count;
    reg        tick;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_count <= 7'h00;
            tick       <= 1'b0;
        end else if (tick_count == `TICK_LAST) begin
            tick_count <= 7'h00;
            tick       <= 1'b1;
        end else begin
            tick_count <= tick_count + 7'h01;
            tick       <= 1'b0;
        end
    end

    // ==========================================================
    // Switch conditioning
    wire [3:0] panel;
    wire       mode_run   = panel[0];
    wire       reset_up   = panel[1];
    wire       reset_down = panel[2];
    wire       card_here  = panel[3];

    switch_debounce #(
        .WIDTH  (4),
        .STABLE (DEBOUNCE_TICKS)
    ) u_debounce (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tick    (tick),
        .raw     ({card_inserted, reset_down_sw, reset_up_sw, mode_run_sw}),
        .stable  (panel)
    );

    reg  mode_prev;
    wire run_rise = mode_run & ~mode_prev;
    wire run_fall = ~mode_run & mode_prev;

    // ==========================================================
    // Registers
    reg  [1:0]           ctrl;
    reg  [`EV_WIDTH-1:0] int_status;
    reg  [`EV_WIDTH-1:0] int_enable;
    reg  [3:0]           state;
    reg  [3:0]           next_state;
    reg  [19:0]          lamp_count;

    wire force_hard = ctrl[`CTRL_FORCE_HARD] | hard_fault;

    // ==========================================================
    // Operating state machine
    always @* begin
        next_state = state;
        case (state)
            `ST_LAMP_TEST: begin
                if (tick && lamp_count == LAMP_LAST)
                    next_state = `ST_SOFT_STOP;
            end
            `ST_RAM_ERASE: begin
                if (ram_erase_done)
                    next_state = card_here ? `ST_CARD_COPY : `ST_SELF_TEST;
            end
            `ST_CARD_COPY: begin
                if (card_copy_done)
                    next_state = `ST_SELF_TEST;
            end
            `ST_SELF_TEST: begin
                // A failed self test has no way out but reset
                if (self_test_fail)
                    next_state = `ST_HARD_STOP;
                else if (self_test_done)
                    next_state = `ST_SOFT_STOP;
            end
            `ST_COLD_CLEAR: begin
                if (state_clear_done)
                    next_state = `ST_ENTRY_BLOCK;
            end
            `ST_ENTRY_BLOCK: begin
                if (entry_block_done)
                    next_state = `ST_RUN;
            end
            `ST_RUN: begin
                if (run_fall)
                    next_state = `ST_SOFT_STOP;
            end
            `ST_SOFT_STOP: begin
                // Reset switch is read only on the stop-to-run move
                if (run_rise) begin
                    if (reset_down)
                        next_state = `ST_RAM_ERASE;
                    else if (reset_up)
                        next_state = `ST_COLD_CLEAR;
                    else
                        next_state = `ST_RUN;
                end
            end
            `ST_HARD_STOP: begin
                // Switches and sequencer are ignored until hresetn
                next_state = `ST_HARD_STOP;
            end
            default: begin
                next_state = `ST_HARD_STOP;
            end
        endcase
        // Fault wins over every sequence step except the lamp test
        if (force_hard && state != `ST_LAMP_TEST)
            next_state = `ST_HARD_STOP;
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state      <= `ST_LAMP_TEST;
            lamp_count <= 20'h0_0000;
            mode_prev  <= 1'b0;
        end else begin
            state <= next_state;
            if (tick && state == `ST_LAMP_TEST)
                lamp_count <= lamp_count + 20'h0_0001;
            // Held low through the lamp test so a selector already at run counts
            mode_prev <= (state == `ST_LAMP_TEST) ? 1'b0 : mode_run;
        end
    end

    // ==========================================================
    // Registered outputs toward lamps and program sequencer
    wire entering = (next_state != state);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_lamp            <= 1'b0;
            stop_lamp           <= 1'b0;
            system_fault_lamp   <= 1'b0;
            ram_erase_req       <= 1'b0;
            card_copy_req       <= 1'b0;
            self_test_req       <= 1'b0;
            state_clear_req     <= 1'b0;
            restart_entry_block <= 1'b0;
            program_restart     <= 1'b0;
            user_program_run    <= 1'b0;
            stop_cycle_block    <= 1'b0;
            outputs_enable      <= 1'b0;
        end else begin
            run_lamp          <= (next_state == `ST_LAMP_TEST) | (next_state == `ST_RUN) |
                                 (next_state == `ST_SELF_TEST);
            stop_lamp         <= (next_state == `ST_LAMP_TEST) | (next_state == `ST_SOFT_STOP) |
                                 (next_state == `ST_SELF_TEST);
            system_fault_lamp <= (next_state == `ST_LAMP_TEST) |
                                 (next_state == `ST_HARD_STOP);
            ram_erase_req       <= (next_state == `ST_RAM_ERASE);
            card_copy_req       <= (next_state == `ST_CARD_COPY);
            self_test_req       <= (next_state == `ST_SELF_TEST);
            state_clear_req     <= (next_state == `ST_COLD_CLEAR);
            restart_entry_block <= (next_state == `ST_ENTRY_BLOCK);
            program_restart     <= entering & (next_state == `ST_RUN);
            user_program_run    <= (next_state == `ST_RUN);
            stop_cycle_block    <= (next_state == `ST_SOFT_STOP) &
                                   ctrl[`CTRL_STOP_BLOCK];
            // Outputs are driven only while the program runs
            outputs_enable      <= (next_state == `ST_RUN);
        end
    end

    // ==========================================================
    // Events
    // One-cycle strobes on state entry, overall-done on leaving self test; the status register keeps them
    wire [`EV_WIDTH-1:0] events;

    assign events[`EV_RUN]          = entering & (next_state == `ST_RUN);
    assign events[`EV_SOFT_STOP]    = entering & (next_state == `ST_SOFT_STOP);
    assign events[`EV_HARD_STOP]    = entering & (next_state == `ST_HARD_STOP);
    assign events[`EV_OVERALL_DONE] = (state == `ST_SELF_TEST) & entering;
    assign events[`EV_COLD_RESTART] = entering & (next_state == `ST_ENTRY_BLOCK);

    // ==========================================================
    // AHB-Lite slave, zero wait states
    // Writes land at the end of the data phase; a read right behind sees the old value
    reg        wr_pend;
    reg  [5:0] wr_index;
    wire       take  = hsel & htrans[1] & hready;
    wire [5:0] index = haddr[7:2];

    function [31:0] read_word;
        input [5:0] idx;
        begin
            case (idx)
                `REG_CTRL:       read_word = {30'h0000_0000, ctrl};
                `REG_STATE:      read_word = {24'h00_0000, card_here, reset_down, reset_up,
                                              mode_run, state};
                `REG_INT_STATUS: read_word = {27'h000_0000, int_status};
                `REG_INT_ENABLE: read_word = {27'h000_0000, int_enable};
                default:         read_word = 32'h0000_0000;
            endcase
        end
    endfunction

    wire [`EV_WIDTH-1:0] clear_bits = (wr_pend && wr_index == `REG_INT_CLEAR) ?
                                      hwdata[`EV_WIDTH-1:0] : `EV_RESET;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata     <= 32'h0000_0000;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            wr_pend    <= 1'b0;
            wr_index   <= 6'h00;
            ctrl       <= `CTRL_RESET;
            int_enable <= `EV_RESET;
            int_status <= `EV_RESET;
            irq        <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend   <= take & hwrite;
            if (take) begin
                wr_index <= index;
                if (!hwrite)
                    hrdata <= read_word(index);
            end
            if (wr_pend && wr_index == `REG_CTRL)
                ctrl <= hwdata[1:0];
            if (wr_pend && wr_index == `REG_INT_ENABLE)
                int_enable <= hwdata[`EV_WIDTH-1:0];
            // A new event wins over a clear in the same cycle
            int_status <= (int_status & ~clear_bits) | events;
            // irq updates on the same edge as status; a new enable counts one cycle after its write edge
            irq        <= |(((int_status & ~clear_bits) | events) & int_enable);
        end
    end

endmodule

// [logic/front_panel_defs.vh]
// Constants for the front-panel mode and restart control block
`ifndef FRONT_PANEL_DEFS_VH
`define FRONT_PANEL_DEFS_VH

// ==========================================================
// Timing
`define CLK_PERIOD_NS   8
`define TICK_NS         1000
`define TICK_CYCLES     (`TICK_NS / `CLK_PERIOD_NS)
`define TICK_LAST       7'h7C
`define DEBOUNCE_US     10000
`define LAMP_TEST_US    500000
`define DEBOUNCE_TICKS  (`DEBOUNCE_US * 1000 / `TICK_NS)
`define LAMP_TEST_TICKS (`LAMP_TEST_US * 1000 / `TICK_NS)

// ==========================================================
// Register word indices, decoded from haddr[7:2]
`define REG_CTRL        6'h00
`define REG_STATE       6'h01
`define REG_INT_STATUS  6'h02
`define REG_INT_CLEAR   6'h03
`define REG_INT_ENABLE  6'h04

// ==========================================================
// Control register fields and reset value
`define CTRL_FORCE_HARD 0
`define CTRL_STOP_BLOCK 1
`define CTRL_RESET      2'h0

// ==========================================================
// Interrupt event bits
`define EV_RUN          0
`define EV_SOFT_STOP    1
`define EV_HARD_STOP    2
`define EV_OVERALL_DONE 3
`define EV_COLD_RESTART 4
`define EV_WIDTH        5
`define EV_RESET        5'h00

// ==========================================================
// Operating states
`define ST_LAMP_TEST    4'h0
`define ST_RAM_ERASE    4'h1
`define ST_CARD_COPY    4'h2
`define ST_SELF_TEST    4'h3
`define ST_COLD_CLEAR   4'h4
`define ST_ENTRY_BLOCK  4'h5
`define ST_RUN          4'h6
`define ST_SOFT_STOP    4'h7
`define ST_HARD_STOP    4'h8

`endif

// [logic/switch_debounce.v]
// Two-flop synchroniser and stability filter for front-panel pins
`timescale 1ns/100ps
`include "front_panel_defs.vh"

module switch_debounce #(
    parameter WIDTH  = 4,
    parameter STABLE = `DEBOUNCE_TICKS
) (
    input  wire             hclk,
    input  wire             hresetn,
    input  wire             tick,
    input  wire [WIDTH-1:0] raw,
    output wire [WIDTH-1:0] stable
);

    localparam integer STABLE_SPAN = STABLE - 1;
    localparam [19:0]  STABLE_LAST = STABLE_SPAN[19:0];

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg        meta;
            reg        sync;
            reg        level;
            reg [19:0] count;

            // First flop feeds only the second
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    meta <= 1'b0;
                    sync <= 1'b0;
                end else begin
                    meta <= raw[i];
                    sync <= meta;
                end
            end

            // Level changes only after it has held for the whole window
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    level <= 1'b0;
                    count <= 20'h0_0000;
                end else if (sync == level) begin
                    count <= 20'h0_0000;
                end else if (tick) begin
                    if (count == STABLE_LAST) begin
                        level <= sync;
                        count <= 20'h0_0000;
                    end else begin
                        count <= count + 20'h0_0001;
                    end
                end
            end

            assign stable[i] = level;
        end
    endgenerate

endmodule

// [test/cpu_mode_control_monitor.sv]
// Concurrent checks on the mode and restart control block's ports
`timescale 1ns/100ps
module mode_control_monitor #(
    parameter DEBOUNCE_TICKS  = 3,
    parameter LAMP_TEST_TICKS = 4
) (
    input wire hclk,
    input wire hresetn,
    input wire mode_run_sw,
    input wire run_lamp,
    input wire stop_lamp,
    input wire system_fault_lamp,
    input wire ram_erase_req,
    input wire card_copy_req,
    input wire self_test_req,
    input wire state_clear_req,
    input wire restart_entry_block,
    input wire program_restart,
    input wire user_program_run,
    input wire stop_cycle_block,
    input wire outputs_enable
);
    localparam int STOP_MAX = (DEBOUNCE_TICKS + 2) * 125 + 8;
    localparam int LT_MAX   = (LAMP_TEST_TICKS + 1) * 125 + 4;
    int lt_cnt;
    // ==========================================
    // Lamp test length, counted over the whole run since reset
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            lt_cnt <= 0;
        else if (run_lamp && stop_lamp && system_fault_lamp)
            lt_cnt <= lt_cnt + 1;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence clear_done;
        $fell(state_clear_req) && !system_fault_lamp;
    endsequence
    sequence entry_done;
        $fell(restart_entry_block) && !system_fault_lamp;
    endsequence
    // ==========================================
    // Properties
    a_run_outputs: assert property (
        outputs_enable |-> user_program_run && run_lamp && !stop_lamp)
        else $error("outputs enabled outside run");
    a_stop_quiet: assert property (
        stop_lamp && !run_lamp |-> !outputs_enable && !user_program_run)
        else $error("soft stop with outputs or program active");
    a_stop_block: assert property (
        stop_cycle_block |-> stop_lamp && !run_lamp && !outputs_enable)
        else $error("stop cycle block outside soft stop");
    a_fault_still: assert property (
        system_fault_lamp && !run_lamp |-> !user_program_run && !stop_cycle_block
            && !outputs_enable && !program_restart)
        else $error("activity in hard stop");
    a_fault_sticky: assert property (
        system_fault_lamp && !run_lamp |=> system_fault_lamp && !run_lamp && !stop_lamp)
        else $error("hard stop left without reset");
    a_lamp_brief: assert property (lt_cnt <= LT_MAX)
        else $error("lamp test too long");
    a_restart_pulse: assert property (
        program_restart |-> user_program_run && run_lamp ##1 !program_restart)
        else $error("restart pulse wrong");
    a_copy_after_erase: assert property (
        $rose(card_copy_req) |-> $past(ram_erase_req, 2) && !ram_erase_req)
        else $error("card copy not after erase");
    a_test_after_init: assert property (
        $rose(self_test_req) |-> $past(card_copy_req, 2) || $past(ram_erase_req, 2))
        else $error("self test not after reinitialisation");
    a_cold_entry: assert property (clear_done |=> restart_entry_block)
        else $error("entry block not called after clear");
    a_entry_resume: assert property (entry_done |-> user_program_run && program_restart)
        else $error("program not resumed after entry block");
    a_switch_settled: assert property (
        $rose(user_program_run) |-> mode_run_sw && $past(mode_run_sw, 300))
        else $error("run entered on unsettled selector");
    a_stop_on_move: assert property (
        user_program_run && $fell(mode_run_sw) |-> ##[1:STOP_MAX] stop_lamp && !run_lamp)
        else $error("no soft stop after selector moved");
endmodule
bind cpu_mode_control mode_control_monitor #(
    .DEBOUNCE_TICKS(DEBOUNCE_TICKS), .LAMP_TEST_TICKS(LAMP_TEST_TICKS)) u_mon (
    .hclk(hclk), .hresetn(hresetn), .mode_run_sw(mode_run_sw), .run_lamp(run_lamp),
    .stop_lamp(stop_lamp), .system_fault_lamp(system_fault_lamp),
    .ram_erase_req(ram_erase_req), .card_copy_req(card_copy_req),
    .self_test_req(self_test_req), .state_clear_req(state_clear_req),
    .restart_entry_block(restart_entry_block), .program_restart(program_restart),
    .user_program_run(user_program_run), .stop_cycle_block(stop_cycle_block),
    .outputs_enable(outputs_enable));

// [test/panel_model.sv]
// Operator switches and sequencer stand-in at the control block's far side
`timescale 1ns/100ps
module panel_model (
    input  wire       hclk,
    input  wire       run_pos,
    input  wire [1:0] reset_pos,
    input  wire       slow,
    input  wire       clr_seen,
    input  wire [4:0] req,
    output wire       mode_run_sw,
    output wire       reset_up_sw,
    output wire       reset_down_sw,
    output reg  [4:0] done,
    output reg  [4:0] seen
);
    reg     [7:0] cnt [0:4];
    integer       i;
    // ==========================================
    // Switch contacts: middle position closes neither
    assign mode_run_sw   = run_pos;
    assign reset_up_sw   = (reset_pos == 2'h1);
    assign reset_down_sw = (reset_pos == 2'h2);
    // ==========================================
    // One done pulse per step; slow answers stretch each step
    always @(posedge hclk) begin
        for (i = 0; i < 5; i = i + 1) begin
            cnt[i]  <= req[i] ? cnt[i] + 8'h01 : 8'h00;
            done[i] <= req[i] && (cnt[i] == (slow ? 8'h14 : 8'h01));
        end
        seen <= clr_seen ? 5'h00 : (seen | req);
    end
endmodule

// [test/test_cpu_mode_control.sv]
// Self-checking bench for the front-panel mode and restart control block
`timescale 1ns/100ps
module test_cpu_mode_control;
    typedef struct packed {
        logic [1:0] pos;
        logic       crd;
        logic       slw;
        logic [4:0] exp_seen;
        logic [3:0] mid;
        logic [3:0] fin;
    } row_t;
    reg          hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    reg   [31:0] haddr = 0, hwdata = 0;
    reg   [1:0]  htrans = 0, reset_pos = 0;
    reg          run_pos = 0, slow = 0, clr_seen = 0, card = 0, hard_fault = 0, fail = 0;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, irq, mode_run_sw, reset_up_sw, reset_down_sw;
    wire         run_lamp, stop_lamp, system_fault_lamp, stop_cycle_block, outputs_enable;
    wire         program_restart, user_program_run;
    wire  [4:0]  req, done, seen;
    integer      errors = 0, cmp_count = 0, r, n;
    logic [31:0] rd;
    row_t        rows [0:4] = '{
        '{2'h0, 1'h0, 1'h0, 5'h00, 4'h6, 4'h6}, '{2'h1, 1'h0, 1'h0, 5'h18, 4'h6, 4'h6},
        '{2'h1, 1'h0, 1'h1, 5'h18, 4'h6, 4'h6}, '{2'h2, 1'h1, 1'h1, 5'h07, 4'h3, 4'h7},
        '{2'h2, 1'h0, 1'h1, 5'h05, 4'h3, 4'h7}};
    always #4 hclk = ~hclk;
    cpu_mode_control #(.DEBOUNCE_TICKS(3), .LAMP_TEST_TICKS(4)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
        .mode_run_sw(mode_run_sw), .reset_up_sw(reset_up_sw), .reset_down_sw(reset_down_sw),
        .card_inserted(card), .run_lamp(run_lamp), .stop_lamp(stop_lamp),
        .system_fault_lamp(system_fault_lamp), .hard_fault(hard_fault),
        .ram_erase_done(done[0]), .card_copy_done(done[1]), .self_test_done(done[2]),
        .self_test_fail(done[2] & fail), .state_clear_done(done[3]), .entry_block_done(done[4]),
        .ram_erase_req(req[0]), .card_copy_req(req[1]), .self_test_req(req[2]),
        .state_clear_req(req[3]), .restart_entry_block(req[4]),
        .program_restart(program_restart), .user_program_run(user_program_run),
        .stop_cycle_block(stop_cycle_block), .outputs_enable(outputs_enable));
    panel_model pm (
        .hclk(hclk), .run_pos(run_pos), .reset_pos(reset_pos), .slow(slow),
        .clr_seen(clr_seen), .req(req), .mode_run_sw(mode_run_sw),
        .reset_up_sw(reset_up_sw), .reset_down_sw(reset_down_sw), .done(done), .seen(seen));
    // ==========================================
    // Helpers
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("ERROR t=%0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Polls the state register; the extra edge lets the lamps catch up
    task wait_state(input logic [31:0] mask, input logic [31:0] val);
        for (n = 0; n < 400; n = n + 1) begin
            bus(1'b0, 32'h0000_0004, 32'h0000_0000);
            if ((rd & mask) === val)
                break;
        end
        @(posedge hclk);
        chk(rd & mask, val, "state");
    endtask
    task lamps(input logic [2:0] exp);
        chk({29'h0, run_lamp, stop_lamp, system_fault_lamp}, {29'h0, exp}, "lamps");
    endtask
    task test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================
    // Sequence
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        lamps(3'h7);
        wait_state(32'h0000_000F, 32'h0000_0007);
        lamps(3'h2);
        $display("power-on test done");
        for (r = 0; r < 5; r = r + 1) begin
            @(posedge hclk);
            reset_pos <= rows[r].pos;
            card <= rows[r].crd;
            slow <= rows[r].slw;
            clr_seen <= 1'b1;
            @(posedge hclk);
            clr_seen <= 1'b0;
            run_pos <= 1'b1;
            wait_state(32'h0000_000F, {28'h0, rows[r].mid});
            wait_state(32'h0000_000F, {28'h0, rows[r].fin});
            chk({27'h0, seen}, {27'h0, rows[r].exp_seen}, "steps");
            chk({31'h0, outputs_enable}, {31'h0, rows[r].fin == 4'h6}, "outputs");
            lamps(rows[r].fin == 4'h6 ? 3'h4 : 3'h2);
            run_pos <= 1'b0;
            wait_state(32'h0000_001F, 32'h0000_0007);
            chk({31'h0, outputs_enable}, 32'h0000_0000, "stop outputs");
            $display("row %0d done", r);
        end
        bus(1'b0, 32'h0000_0008, 32'h0000_0000);
        chk(rd, 32'h0000_001B, "events");
        bus(1'b1, 32'h0000_0010, 32'h0000_0002);
        bus(1'b0, 32'h0000_0010, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0001, "irq on");
        chk({31'h0, hresp}, 32'h0000_0000, "hresp");
        bus(1'b1, 32'h0000_0010, 32'h0000_0000);
        bus(1'b0, 32'h0000_0020, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000, "irq masked");
        chk(rd, 32'h0000_0000, "unmapped");
        bus(1'b1, 32'h0000_0010, 32'h0000_0002);
        bus(1'b1, 32'h0000_000C, 32'h0000_001F);
        bus(1'b0, 32'h0000_0008, 32'h0000_0000);
        chk(rd, 32'h0000_0000, "cleared");
        chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
        bus(1'b1, 32'h0000_0000, 32'h0000_0002);
        bus(1'b0, 32'h0000_0000, 32'h0000_0000);
        chk(rd, 32'h0000_0002, "ctrl");
        chk({31'h0, stop_cycle_block}, 32'h0000_0001, "stop block");
        $display("register test done");
        run_pos <= 1'b1;
        reset_pos <= 2'h0;
        wait_state(32'h0000_000F, 32'h0000_0006);
        hard_fault <= 1'b1;
        @(posedge hclk);
        hard_fault <= 1'b0;
        wait_state(32'h0000_000F, 32'h0000_0008);
        lamps(3'h1);
        run_pos <= 1'b0;
        reset_pos <= 2'h2;
        wait_state(32'h0000_001F, 32'h0000_0008);
        chk({31'h0, user_program_run}, 32'h0000_0000, "standstill");
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        lamps(3'h7);
        bus(1'b0, 32'h0000_0010, 32'h0000_0000);
        chk(rd, 32'h0000_0000, "enable reset");
        bus(1'b0, 32'h0000_0000, 32'h0000_0000);
        chk(rd, 32'h0000_0000, "ctrl reset");
        wait_state(32'h0000_000F, 32'h0000_0007);
        $display("hard stop test done");
        bus(1'b1, 32'h0000_0000, 32'h0000_0001);
        wait_state(32'h0000_000F, 32'h0000_0008);
        lamps(3'h1);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        wait_state(32'h0000_000F, 32'h0000_0007);
        fail <= 1'b1;
        run_pos <= 1'b1;
        wait_state(32'h0000_000F, 32'h0000_0008);
        lamps(3'h1);
        $display("fault path test done");
        test_done;
    end
    initial begin
        repeat (60000) @(posedge hclk);
        errors = errors + 1;
        $display("ERROR t=%0t watchdog expired", $time);
        test_done;
    end
endmodule
